// ===== verilog/slt_pkg.sv
package slt_pkg;

    // ****************************************
    // register addresses
    // ****************************************
    localparam logic [7:0] ADDR_CONFIG = 8'h95;
    localparam logic [7:0] ADDR_CLOCK = 8'h96;
    localparam logic [7:0] ADDR_SEG_HI = 8'h97;
    localparam logic [7:0] ADDR_POINTER = 8'hAC;
    localparam logic [7:0] ADDR_DATA = 8'hAE;
    localparam logic [7:0] ADDR_SEG_LO = 8'hED;

    // ****************************************
    // field positions and masks
    // ****************************************
    localparam int CFG_CLOCK_SOURCE_SELECT_BIT = 3;
    localparam int CFG_BLINK_BIT = 5;
    localparam int CFG_CLEAR_BIT = 6;
    localparam logic [7:0] CFG_MASK = 8'h2B;
    localparam int PTR_WRITE_BIT = 7;
    localparam logic [7:0] PTR_MASK = 8'hBF;
    localparam logic [7:0] SEG_HI_MASK = 8'hFC;
    localparam logic [7:0] SEG_LO_MASK = 8'h0F;
    localparam logic [7:0] RESET_BYTE = 8'h00;

    // ****************************************
    // display memory and pin layout
    // ****************************************
    localparam int MEM_BYTES = 15;
    localparam logic [5:0] MEM_LAST = 6'h0E;
    localparam int SEG_LINES = 29;
    localparam int SEG_SHARED_LO = 16;
    localparam int SEG_SHARED_HI = 25;
    localparam int SEG_ALWAYS = 26;
    localparam int SEG_COMMON_LINE_3 = 27;
    localparam int SEG_COMMON_LINE_2 = 28;
    localparam int SEG_HI_BASE = 20;

    // ****************************************
    // multiplex levels, blink modes and rates
    // ****************************************
    localparam logic [1:0] MUX_3X = 2'h2;
    localparam logic [1:0] MUX_4X = 2'h3;
    localparam logic [1:0] BLK_OFF = 2'h0;
    localparam logic [1:0] BLK_ON = 2'h1;
    localparam logic [1:0] BLK_2HZ = 2'h2;
    // half blink periods counted in 128 Hz source edges (256 per second)
    localparam logic [9:0] BLK_HALF_2HZ = 10'h040;
    localparam logic [9:0] BLK_HALF_1HZ = 10'h080;
    localparam logic [9:0] BLK_HALF_UNIT = 10'h080;

    // half waveform steps counted in source edges
    localparam logic [5:0] FD_ZERO_N = 6'h20;
    localparam logic [5:0] FD_3X_MIN = 6'h03;
    localparam logic [3:0] FD_ALL_ONES = 4'hF;
    localparam logic [3:0] FD_ONE = 4'h1;
    localparam logic [3:0] FD_TWO = 4'h2;
    localparam logic [6:0] SLOW_FD15 = 7'h01;
    localparam logic [6:0] SLOW_FD0 = 7'h02;
    localparam logic [6:0] SLOW_2X_FD1 = 7'h04;
    localparam logic [6:0] SLOW_2X_FD2 = 7'h06;
    localparam logic [6:0] SLOW_2X_REST = 7'h08;
    localparam logic [6:0] SLOW_OTHER = 7'h04;

    // ****************************************
    // carrier types
    // ****************************************
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } slt_sfr_req_t;

    typedef struct packed {
        logic [3:0] com_active;
        logic invert;
        logic frame_start;
    } slt_wave_t;

endpackage

// ===== verilog/slt_timing_ctrl.sv
`timescale 1ns/100ps

// Summary of operation
// - config bit 3 picks 2048 or 128 Hz
// - slow clock divider codes follow table
// - slow codes 1111 and 0000 special rates
// - fast clock gives sixteen divider rates, fifteen in 3x mux
// - clock, mux, divider jointly set rates
// - waveform inverts at twice waveform rate
// - mux codes 2,3 turn lines into commons
// - lines 0-15 and 26 always segments
// - high enable bits 7:2 pick lines 25:20
// - low enable bits 3:0 pick lines 19:16
// - shared lines enabled independently, else alternate
// - pointer write bit7 stores data byte
// - eight bit data register, resets zero
// - clear bit zeroes all display memory
// - reset also zeroes display memory
// - blink enable alternates display on/off
// - auto blink needs rtc enable input
// - blink modes off, on, 2 Hz, field
// - blink field gives 1,1/2,1/3,1/4 Hz
// - pointer write bit7 clear loads data
// - fifteen bytes, even low nibble, odd high
module slt_timing_ctrl (
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST,
    // special function register access
    input wire slt_pkg::slt_sfr_req_t SFR_REQ,
    output logic [7:0] SFR_RDATA,
    // slow time sources and rtc state, asynchronous
    input wire logic SRC_2048_IN,
    input wire logic SRC_128_IN,
    input wire logic RTC_ENABLE_IN,
    // glass drive
    output slt_pkg::slt_wave_t WAVE,
    output logic [28:0] SEG_STATE,
    output logic [28:0] SEG_IS_LCD,
    output logic COMMON_LINE_2_ON_PIN,
    output logic COMMON_LINE_3_ON_PIN,
    output logic DISPLAY_ON
);

    // ****************************************
    // registers
    // ****************************************
    logic [7:0] cfg_q;
    logic [7:0] clk_reg_q;
    logic [7:0] seg_hi_q;
    logic [7:0] seg_lo_q;
    logic [7:0] ptr_q;
    logic [7:0] data_q;
    logic [7:0] mem_q [slt_pkg::MEM_BYTES];
    logic [7:0] rdata_q;

    wire wr_cfg = SFR_REQ.wr && (SFR_REQ.addr == slt_pkg::ADDR_CONFIG);
    wire wr_clk = SFR_REQ.wr && (SFR_REQ.addr == slt_pkg::ADDR_CLOCK);
    wire wr_hi = SFR_REQ.wr && (SFR_REQ.addr == slt_pkg::ADDR_SEG_HI);
    wire wr_lo = SFR_REQ.wr && (SFR_REQ.addr == slt_pkg::ADDR_SEG_LO);
    wire wr_ptr = SFR_REQ.wr && (SFR_REQ.addr == slt_pkg::ADDR_POINTER);
    wire wr_dat = SFR_REQ.wr && (SFR_REQ.addr == slt_pkg::ADDR_DATA);
    wire [5:0] acc_addr = SFR_REQ.wdata[5:0];
    wire acc_write = SFR_REQ.wdata[slt_pkg::PTR_WRITE_BIT];
    wire acc_in_range = acc_addr <= slt_pkg::MEM_LAST;
    wire mem_clear = wr_cfg && SFR_REQ.wdata[slt_pkg::CFG_CLEAR_BIT];

    wire clock_source_select = cfg_q[slt_pkg::CFG_CLOCK_SOURCE_SELECT_BIT];
    wire [1:0] mux_level = cfg_q[1:0];
    wire blink_enable = cfg_q[slt_pkg::CFG_BLINK_BIT];
    wire [1:0] blink_mode = clk_reg_q[7:6];
    wire [1:0] blink_frequency = clk_reg_q[5:4];
    wire [3:0] frame_divider = clk_reg_q[3:0];

    // ****************************************
    // register writes
    // ****************************************
    // clear bit is a strobe, never stored, so it reads back zero
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            cfg_q <= slt_pkg::RESET_BYTE;
            clk_reg_q <= slt_pkg::RESET_BYTE;
            seg_hi_q <= slt_pkg::RESET_BYTE;
            seg_lo_q <= slt_pkg::RESET_BYTE;
            ptr_q <= slt_pkg::RESET_BYTE;
        end else begin
            if (wr_cfg) cfg_q <= SFR_REQ.wdata & slt_pkg::CFG_MASK;
            if (wr_clk) clk_reg_q <= SFR_REQ.wdata;
            if (wr_hi) seg_hi_q <= SFR_REQ.wdata & slt_pkg::SEG_HI_MASK;
            if (wr_lo) seg_lo_q <= SFR_REQ.wdata & slt_pkg::SEG_LO_MASK;
            if (wr_ptr) ptr_q <= SFR_REQ.wdata & slt_pkg::PTR_MASK;
        end
    end

    // a read access returns zero for an address past the last byte
    wire [7:0] rd_byte = acc_in_range ? mem_q[acc_addr[3:0]] : slt_pkg::RESET_BYTE;

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            data_q <= slt_pkg::RESET_BYTE;
        end else if (wr_ptr && !acc_write) begin
            data_q <= rd_byte;
        end else if (wr_dat) begin
            data_q <= SFR_REQ.wdata;
        end
    end

    // ****************************************
    // display memory
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < slt_pkg::MEM_BYTES; gi++) begin : g_mem
            wire hit = wr_ptr && acc_write && (acc_addr == 6'(gi));
            always_ff @(posedge CLOCK) begin
                if (RST) begin
                    mem_q[gi] <= slt_pkg::RESET_BYTE;
                end else if (mem_clear) begin
                    mem_q[gi] <= slt_pkg::RESET_BYTE;
                end else if (hit) begin
                    mem_q[gi] <= data_q;
                end
            end
        end
    endgenerate

    // ****************************************
    // register reads
    // ****************************************
    wire [7:0] rd_mux =
        (SFR_REQ.addr == slt_pkg::ADDR_CONFIG) ? cfg_q :
        (SFR_REQ.addr == slt_pkg::ADDR_CLOCK) ? clk_reg_q :
        (SFR_REQ.addr == slt_pkg::ADDR_SEG_HI) ? seg_hi_q :
        (SFR_REQ.addr == slt_pkg::ADDR_SEG_LO) ? seg_lo_q :
        (SFR_REQ.addr == slt_pkg::ADDR_POINTER) ? ptr_q :
        (SFR_REQ.addr == slt_pkg::ADDR_DATA) ? data_q : slt_pkg::RESET_BYTE;

    always_ff @(posedge CLOCK) begin
        if (RST) rdata_q <= slt_pkg::RESET_BYTE;
        else rdata_q <= rd_mux;
    end

    // ****************************************
    // input synchronisers
    // ****************************************
    // third stage only feeds edge detection, first stays private
    logic [2:0] s2048_q;
    logic [2:0] s128_q;
    logic [1:0] rtc_q;

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            s2048_q <= 3'h0;
            s128_q <= 3'h0;
            rtc_q <= 2'h0;
        end else begin
            s2048_q <= {s2048_q[1:0], SRC_2048_IN};
            s128_q <= {s128_q[1:0], SRC_128_IN};
            rtc_q <= {rtc_q[0], RTC_ENABLE_IN};
        end
    end

    // both edges count, giving events at twice the source rate
    wire ev_2048 = s2048_q[2] ^ s2048_q[1];
    wire ev_128 = s128_q[2] ^ s128_q[1];
    wire ev_src = clock_source_select ? ev_128 : ev_2048;
    wire rtc_enable = rtc_q[1];

    // ****************************************
    // waveform step length
    // ****************************************
    wire [5:0] fd_n = (frame_divider == 4'h0) ? slt_pkg::FD_ZERO_N : {2'h0, frame_divider} + 6'h1;
    wire [5:0] fd_n3 = (fd_n < slt_pkg::FD_3X_MIN) ? slt_pkg::FD_3X_MIN : fd_n;
    wire is_2x = (mux_level != slt_pkg::MUX_3X) && (mux_level != slt_pkg::MUX_4X);
    // eight bits, since a 2x step at code 0000 is 128 source edges long
    wire [7:0] fast_half =
        is_2x ? {fd_n, 2'h0} :
        (mux_level == slt_pkg::MUX_3X) ? {1'b0, fd_n3, 1'h0} : {1'b0, fd_n, 1'h0};
    wire [6:0] slow_2x =
        (frame_divider == slt_pkg::FD_ONE) ? slt_pkg::SLOW_2X_FD1 :
        (frame_divider == slt_pkg::FD_TWO) ? slt_pkg::SLOW_2X_FD2 : slt_pkg::SLOW_2X_REST;
    wire [6:0] slow_half =
        (frame_divider == slt_pkg::FD_ALL_ONES) ? slt_pkg::SLOW_FD15 :
        (frame_divider == 4'h0) ? slt_pkg::SLOW_FD0 :
        is_2x ? slow_2x : slt_pkg::SLOW_OTHER;
    wire [7:0] half_len = clock_source_select ? {1'b0, slow_half} : fast_half;
    wire [1:0] com_last = is_2x ? 2'h1 : mux_level;

    // ****************************************
    // common stepping and inversion
    // ****************************************
    logic [7:0] step_cnt_q;
    logic inv_q;
    logic [1:0] com_q;
    logic frame_q;

    wire step_end = ev_src && (step_cnt_q + 8'h1 >= half_len);
    wire com_adv = step_end && inv_q;
    wire com_wrap = com_q >= com_last;

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            step_cnt_q <= 8'h0;
            inv_q <= 1'b0;
            com_q <= 2'h0;
            frame_q <= 1'b0;
        end else begin
            frame_q <= com_adv && com_wrap;
            if (step_end) step_cnt_q <= 8'h0;
            else if (ev_src) step_cnt_q <= step_cnt_q + 8'h1;
            if (step_end) inv_q <= !inv_q;
            if (com_adv) com_q <= com_wrap ? 2'h0 : com_q + 2'h1;
        end
    end

    // ****************************************
    // blink control
    // ****************************************
    // the blink timebase always runs from the 128 Hz source edges
    logic [9:0] blk_cnt_q;
    logic blk_phase_q;

    wire [9:0] blk_half =
        (blink_mode == slt_pkg::BLK_2HZ) ? slt_pkg::BLK_HALF_2HZ :
        slt_pkg::BLK_HALF_UNIT * ({8'h0, blink_frequency} + 10'h1);
    wire blk_auto = blink_mode[1] && rtc_enable;
    wire blk_end = ev_128 && (blk_cnt_q + 10'h1 >= blk_half);

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            blk_cnt_q <= 10'h0;
            blk_phase_q <= 1'b1;
        end else if (!blk_auto) begin
            blk_cnt_q <= 10'h0;
            blk_phase_q <= 1'b1;
        end else if (blk_end) begin
            blk_cnt_q <= 10'h0;
            blk_phase_q <= !blk_phase_q;
        end else if (ev_128) begin
            blk_cnt_q <= blk_cnt_q + 10'h1;
        end
    end

    // without the rtc the automatic codes simply hold the display on
    wire disp_on =
        !blink_enable ? 1'b1 :
        (blink_mode == slt_pkg::BLK_OFF) ? 1'b0 :
        (blink_mode == slt_pkg::BLK_ON) ? 1'b1 : blk_phase_q;

    // ****************************************
    // segment mapping
    // ****************************************
    wire common_line_2_pin = mux_level == slt_pkg::MUX_3X || mux_level == slt_pkg::MUX_4X;
    wire common_line_3_pin = mux_level == slt_pkg::MUX_4X;
    wire [28:0] seg_lcd;
    wire [28:0] seg_bit;

    generate
        for (gi = 0; gi < slt_pkg::SEG_LINES; gi++) begin : g_seg
            if (gi < slt_pkg::SEG_SHARED_LO || gi == slt_pkg::SEG_ALWAYS) begin : g_fix
                assign seg_lcd[gi] = 1'b1;
            end else if (gi < slt_pkg::SEG_HI_BASE) begin : g_lo
                assign seg_lcd[gi] = seg_lo_q[gi - slt_pkg::SEG_SHARED_LO];
            end else if (gi <= slt_pkg::SEG_SHARED_HI) begin : g_hi
                assign seg_lcd[gi] = seg_hi_q[gi - slt_pkg::SEG_HI_BASE + 2];
            end else if (gi == slt_pkg::SEG_COMMON_LINE_3) begin : g_c3
                assign seg_lcd[gi] = !common_line_3_pin;
            end else begin : g_c2
                assign seg_lcd[gi] = !common_line_2_pin;
            end
            assign seg_bit[gi] = mem_q[gi / 2][(gi % 2) * 4 + com_q];
        end
    endgenerate

    // ****************************************
    // output registers
    // ****************************************
    logic [28:0] seg_state_q;
    logic [28:0] seg_is_lcd_q;
    logic [3:0] com_act_q;
    logic inv_out_q;
    logic common_line_2_q;
    logic common_line_3_q;
    logic disp_q;

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            seg_state_q <= 29'h0;
            seg_is_lcd_q <= 29'h0;
            com_act_q <= 4'h0;
            inv_out_q <= 1'b0;
            common_line_2_q <= 1'b0;
            common_line_3_q <= 1'b0;
            disp_q <= 1'b0;
        end else begin
            seg_state_q <= disp_on ? (seg_bit & seg_lcd) : 29'h0;
            seg_is_lcd_q <= seg_lcd;
            com_act_q <= 4'h1 << com_q;
            inv_out_q <= inv_q;
            common_line_2_q <= common_line_2_pin;
            common_line_3_q <= common_line_3_pin;
            disp_q <= disp_on;
        end
    end

    assign SFR_RDATA = rdata_q;
    assign WAVE.com_active = com_act_q;
    assign WAVE.invert = inv_out_q;
    assign WAVE.frame_start = frame_q;
    assign SEG_STATE = seg_state_q;
    assign SEG_IS_LCD = seg_is_lcd_q;
    assign COMMON_LINE_2_ON_PIN = common_line_2_q;
    assign COMMON_LINE_3_ON_PIN = common_line_3_q;
    assign DISPLAY_ON = disp_q;

endmodule

// ===== tb/slt_glass_model.sv
`timescale 1ns/100ps
// ********
// glass model: counts frames and polarity flips per common step
// ********
module slt_glass_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // drive from the controller
    input wire slt_pkg::slt_wave_t wave,
    // health counters for the bench
    output int bad,
    output int frames
);
    logic [3:0] com_q;
    logic inv_q;
    int flips_q;
    wire flip = wave.invert !== inv_q;
    // a cell sees zero net dc only with two polarity flips per common step
    always_ff @(posedge clk) begin
        if (rst) begin
            com_q <= 4'h0;
            inv_q <= 1'b0;
            flips_q <= 0;
            bad <= 0;
            frames <= 0;
        end else begin
            inv_q <= wave.invert;
            com_q <= wave.com_active;
            frames <= frames + int'(wave.frame_start);
            if (wave.com_active !== com_q) begin
                flips_q <= 0;
                if (com_q != 4'h0 && flips_q + int'(flip) != 2) begin
                    bad <= bad + 1;
                end
            end else begin
                flips_q <= flips_q + int'(flip);
            end
        end
    end
endmodule

// ===== tb/slt_timing_ctrl_properties.sv
`timescale 1ns/100ps
module slt_timing_ctrl_properties (
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST,
    // register access
    input wire slt_pkg::slt_sfr_req_t SFR_REQ,
    input wire logic [7:0] SFR_RDATA,
    // time sources
    input wire logic SRC_2048_IN,
    input wire logic SRC_128_IN,
    input wire logic RTC_ENABLE_IN,
    // glass drive
    input wire slt_pkg::slt_wave_t WAVE,
    input wire logic [28:0] SEG_STATE,
    input wire logic [28:0] SEG_IS_LCD,
    input wire logic COMMON_LINE_2_ON_PIN,
    input wire logic COMMON_LINE_3_ON_PIN,
    input wire logic DISPLAY_ON
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (RST);
    wire unmapped = !(SFR_REQ.addr inside {slt_pkg::ADDR_CONFIG, slt_pkg::ADDR_CLOCK,
        slt_pkg::ADDR_SEG_HI, slt_pkg::ADDR_POINTER, slt_pkg::ADDR_DATA, slt_pkg::ADDR_SEG_LO});
    com_onehot_a: assert property (WAVE.com_active != 4'h0 |-> $onehot(WAVE.com_active))
        else $error("active common not one-hot");
    frame_pulse_a: assert property (WAVE.frame_start |=> !WAVE.frame_start)
        else $error("frame start longer than one cycle");
    invert_hold_a: assert property ($changed(WAVE.invert) |=> $stable(WAVE.invert) [*3])
        else $error("polarity flipped too soon");
    common_line_2_pin_a: assert property (COMMON_LINE_2_ON_PIN |-> !SEG_IS_LCD[28])
        else $error("line 28 both common and segment");
    common_line_3_pin_a: assert property (COMMON_LINE_3_ON_PIN |-> COMMON_LINE_2_ON_PIN && !SEG_IS_LCD[27])
        else $error("line 27 common without line 28");
    fixed_seg_a: assert property (!$past(RST) |-> (SEG_IS_LCD & 29'h0400FFFF) == 29'h0400FFFF)
        else $error("fixed segment line not driven");
    seg_gate_a: assert property ((SEG_STATE & ~SEG_IS_LCD) == 29'h0)
        else $error("segment drive on alternate pin");
    dark_display_a: assert property ((!DISPLAY_ON) [*2] |-> SEG_STATE == 29'h0)
        else $error("segments lit while display off");
    unmapped_read_a: assert property (unmapped |=> SFR_RDATA == 8'h00)
        else $error("unmapped read not zero");
    seg_hi_rsv_a: assert property (SFR_REQ.addr == slt_pkg::ADDR_SEG_HI |=> SFR_RDATA[1:0] == 2'h0)
        else $error("reserved enable bits read back");
    ptr_rsv_a: assert property (SFR_REQ.addr == slt_pkg::ADDR_POINTER |=> !SFR_RDATA[6])
        else $error("reserved pointer bit read back");
endmodule
bind slt_timing_ctrl slt_timing_ctrl_properties props (.CLOCK(CLOCK), .RST(RST),
    .SFR_REQ(SFR_REQ), .SFR_RDATA(SFR_RDATA), .SRC_2048_IN(SRC_2048_IN),
    .SRC_128_IN(SRC_128_IN), .RTC_ENABLE_IN(RTC_ENABLE_IN), .WAVE(WAVE),
    .SEG_STATE(SEG_STATE), .SEG_IS_LCD(SEG_IS_LCD), .COMMON_LINE_2_ON_PIN(COMMON_LINE_2_ON_PIN),
    .COMMON_LINE_3_ON_PIN(COMMON_LINE_3_ON_PIN), .DISPLAY_ON(DISPLAY_ON));

// ===== tb/segment_lcd_timing_ctrl_tb_top.sv
`timescale 1ns/100ps
module segment_lcd_timing_ctrl_tb_top;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic src_fast = 1'b0;
    logic src_slow = 1'b0;
    logic rtc_en = 1'b0;
    slt_pkg::slt_sfr_req_t req = '0;
    logic [7:0] rdata;
    slt_pkg::slt_wave_t wave;
    logic [28:0] seg_state;
    logic [28:0] seg_is_lcd;
    logic common_line_2_pin;
    logic common_line_3_pin;
    logic disp_on;
    logic [7:0] got;
    logic [3:0] c0;
    int glass_bad;
    int glass_frames;
    int mismatches = 0;
    int tests_run = 0;
    int mem [15];
    logic [7:0] reset_addrs [7] = '{8'h95, 8'h96, 8'h97, 8'hAC, 8'hAE, 8'hED, 8'h50};
    int hi, lo, n, c, m, s, k, a, d, fd;
    // source edges every 8 and 10 cycles, far faster than real, same counts
    always #2 clock = ~clock;
    always #32 src_fast = ~src_fast;
    always #40 src_slow = ~src_slow;
    slt_timing_ctrl dut (.CLOCK(clock), .RST(rst), .SFR_REQ(req), .SFR_RDATA(rdata),
        .SRC_2048_IN(src_fast), .SRC_128_IN(src_slow), .RTC_ENABLE_IN(rtc_en), .WAVE(wave),
        .SEG_STATE(seg_state), .SEG_IS_LCD(seg_is_lcd), .COMMON_LINE_2_ON_PIN(common_line_2_pin),
        .COMMON_LINE_3_ON_PIN(common_line_3_pin), .DISPLAY_ON(disp_on));
    slt_glass_model glass (.clk(clock), .rst(rst), .wave(wave), .bad(glass_bad),
        .frames(glass_frames));
    // ********
    // checks and bus tasks
    // ********
    task automatic note(input bit ok, input string w);
        tests_run++;
        if (!ok) begin
            mismatches++;
            $display("Error at %0t: %s", $time, w);
        end
    endtask
    task automatic chk_reg(input logic [7:0] g, input logic [7:0] e);
        note(g === e, "register value");
    endtask
    task automatic chk_pin(input logic [28:0] g, input logic [28:0] e);
        note(g === e, "pin state");
    endtask
    task automatic chk_cyc(input int g, input int e);
        note(g == e, "cycle count");
    endtask
    task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
        req.wr = 1'b1;
        req.addr = ad;
        req.wdata = dt;
        @(negedge clock);
        req.wr = 1'b0;
        @(negedge clock);
    endtask
    task automatic rd(input logic [7:0] ad, output logic [7:0] dt);
        req.addr = ad;
        @(negedge clock);
        dt = rdata;
    endtask
    function automatic logic pick(input int sel);
        return sel == 0 ? wave.invert : sel == 1 ? wave.frame_start : disp_on;
    endfunction
    // rise to rise; the first wait drops the partial period after a change
    task automatic period(input int sel, output int cnt);
        logic prev;
        for (int i = 0; i < 2; i++) begin
            cnt = 0;
            do begin
                prev = pick(sel);
                @(negedge clock);
                cnt++;
            end while (!(prev === 1'b0 && pick(sel) === 1'b1) && cnt < 40000);
        end
    endtask
    function automatic int half_len(input int slow, input int mx, input int f);
        int q;
        q = (f == 0) ? 32 : f + 1;
        if (slow == 0) return mx < 2 ? 4 * q : mx == 2 ? 2 * (q < 3 ? 3 : q) : 2 * q;
        if (f == 15) return 1;
        if (f == 0) return 2;
        if (mx >= 2) return 4;
        return f == 1 ? 4 : f == 2 ? 6 : 8;
    endfunction
    function automatic logic [28:0] exp_lcd(input int h, input int l, input int mx);
        logic [28:0] e;
        e = 29'h1C00FFFF;
        e[25:20] = h[7:2];
        e[19:16] = l[3:0];
        if (mx >= 2) e[28] = 1'b0;
        if (mx == 3) e[27] = 1'b0;
        return e;
    endfunction
    function automatic logic [28:0] exp_seg(input logic [28:0] lcd, input int cm);
        logic [28:0] e;
        for (int l = 0; l < 29; l++) e[l] = lcd[l] & mem[l / 2][4 * (l % 2) + cm];
        return e;
    endfunction
    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge clock);
        mismatches++;
        summarize();
    end
    // ********
    // main sequence
    // ********
    initial begin
        n = $urandom(27);
        repeat (20) @(negedge clock);
        rst = 1'b0;
        repeat (2) @(negedge clock);
        chk_pin(seg_is_lcd, exp_lcd(0, 0, 0));
        foreach (reset_addrs[i]) begin
            rd(reset_addrs[i], got);
            chk_reg(got, 8'h00);
        end
        $display("reset test done");
        for (k = 0; k < 3; k++) begin
            hi = (k == 2) ? 255 : $urandom % 256;
            lo = (k == 2) ? 255 : $urandom % 256;
            wr(slt_pkg::ADDR_SEG_HI, 8'(hi));
            wr(slt_pkg::ADDR_SEG_LO, 8'(lo));
            rd(slt_pkg::ADDR_SEG_HI, got);
            chk_reg(got, 8'(hi) & 8'hFC);
            rd(slt_pkg::ADDR_SEG_LO, got);
            chk_reg(got, 8'(lo) & 8'h0F);
            chk_pin(seg_is_lcd, exp_lcd(hi, lo, 0));
        end
        $display("segment enable test done");
        for (a = 0; a < 16; a++) begin
            d = $urandom % 256;
            if (a < 15) mem[a] = d;
            wr(slt_pkg::ADDR_DATA, 8'(d));
            wr(slt_pkg::ADDR_POINTER, 8'(a + 192));
            rd(slt_pkg::ADDR_POINTER, got);
            chk_reg(got, 8'(a + 128));
        end
        for (a = 0; a < 16; a++) begin
            wr(slt_pkg::ADDR_POINTER, 8'(a));
            rd(slt_pkg::ADDR_DATA, got);
            chk_reg(got, a < 15 ? 8'(mem[a]) : 8'h00);
        end
        wr(slt_pkg::ADDR_CONFIG, 8'h03);
        wr(slt_pkg::ADDR_CLOCK, 8'h0F);
        for (k = 0; k < 4; k++) begin
            c0 = wave.com_active;
            for (n = 0; n < 2000 && wave.com_active === c0; n++) @(negedge clock);
            repeat (4) @(negedge clock);
            for (c = 0; c < 3 && wave.com_active[c] !== 1'b1; c++);
            chk_pin(seg_state, exp_seg(exp_lcd(255, 255, 3), c));
        end
        wr(slt_pkg::ADDR_CONFIG, 8'h43);
        wr(slt_pkg::ADDR_POINTER, 8'h05);
        rd(slt_pkg::ADDR_DATA, got);
        chk_reg(got, 8'h00);
        chk_pin(seg_state, 29'h0);
        wr(slt_pkg::ADDR_DATA, 8'h5A);
        wr(slt_pkg::ADDR_POINTER, 8'h80);
        chk_cyc(glass_bad, 0);
        rst = 1'b1;
        repeat (3) @(negedge clock);
        rst = 1'b0;
        wr(slt_pkg::ADDR_POINTER, 8'h00);
        rd(slt_pkg::ADDR_DATA, got);
        chk_reg(got, 8'h00);
        $display("display memory test done");
        hi = 0;
        lo = 15;
        wr(slt_pkg::ADDR_SEG_LO, 8'h0F);
        for (m = 0; m < 4; m++) begin
            for (s = 0; s < 2; s++) begin
                for (k = 0; k < 5; k++) begin
                    fd = k == 0 ? 0 : k == 1 ? 1 : k == 2 ? 2 : k == 3 ? 15 : 3 + $urandom % 12;
                    wr(slt_pkg::ADDR_CONFIG, 8'(m + 8 * s));
                    wr(slt_pkg::ADDR_CLOCK, 8'(fd));
                    chk_pin(seg_is_lcd, exp_lcd(hi, lo, m));
                    chk_pin(29'({common_line_3_pin, common_line_2_pin}), 29'(m < 2 ? 0 : m == 2 ? 1 : 3));
                    if (m != 1) begin
                        period(0, n);
                        chk_cyc(n, 2 * half_len(s, m, fd) * (s ? 10 : 8));
                    end
                    if (fd == 1 && m != 1) begin
                        period(1, n);
                        chk_cyc(n, (m < 2 ? 2 : m + 1) * 2 * half_len(s, m, fd) * (s ? 10 : 8));
                    end
                end
            end
        end
        $display("timing test done");
        rtc_en = 1'b1;
        wr(slt_pkg::ADDR_CONFIG, 8'h20);
        for (k = 0; k < 2; k++) begin
            wr(slt_pkg::ADDR_CLOCK, 8'(k * 64));
            repeat (8) @(negedge clock);
            chk_pin(29'(disp_on), 29'(k));
        end
        for (k = 0; k < 5; k++) begin
            wr(slt_pkg::ADDR_CLOCK, k == 0 ? 8'h80 : 8'(192 + 16 * (k - 1)));
            period(2, n);
            chk_cyc(n, 20 * (k == 0 ? 64 : 128 * k));
        end
        rtc_en = 1'b0;
        repeat (8) @(negedge clock);
        chk_pin(29'(disp_on), 29'h1);
        wr(slt_pkg::ADDR_CONFIG, 8'h00);
        wr(slt_pkg::ADDR_CLOCK, 8'h00);
        repeat (4) @(negedge clock);
        chk_pin(29'(disp_on), 29'h1);
        chk_cyc(glass_bad, 0);
        note(glass_frames > 0, "no frames seen");
        $display("blink test done");
        summarize();
    end
endmodule
